// ==== bench/pof_coil_model.sv ====
// Purpose: Coil, switch and sense model of one phase
// Assumes: Ideal comparators synchronous to clk
// Notes:   mode 0 normal, 1 open coil, 2 turn-off spike
`timescale 1ns/1ps
module pof_coil_model
  import pof_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [1:0] gate,
  input  wire logic       dir,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] on_len,
  output logic            trip,
  output logic            pos
);
  logic       on;
  logic       on_r = 1'b0;
  logic [8:0] cnt_r = 9'h000;
  assign on = dir ? gate[1] : gate[0];
  always_ff @(posedge clk) begin
    on_r  <= on;
    cnt_r <= (on != on_r) ? 9'h000 : cnt_r + {8'h00, cnt_r != 9'h1ff};
  end
  assign trip = on && (cnt_r >= {1'b0, on_len});
  assign pos = !on && ((mode == 2'h1) ? (cnt_r > 9'h03c) : (mode == 2'h2 && cnt_r < 9'h01e));
endmodule : pof_coil_model

// ==== bench/pof_drive_ctrl_props.sv ====
// Purpose: Assertions on pof_drive_ctrl ports
// Assumes: rst synchronous, active high
// Notes:   Phase A timing, both phases for faults
`timescale 1ns/1ps
module pof_drive_ctrl_props
  import pof_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] trip_cmp,
  input wire logic [1:0] short_cmp,
  input wire logic       thermal_trip,
  input wire logic [1:0] gate_a,
  input wire logic [1:0] gate_b,
  input wire logic [1:0] pwm_on,
  input wire logic [1:0] open_event,
  input wire logic       fault
);
  logic [7:0] on_cnt_r;
  logic [7:0] on_cnt_nxt;
  assign on_cnt_nxt = !pwm_on[0] ? 8'h00 : on_cnt_r + {7'h00, on_cnt_r != 8'hff};
  always_ff @(posedge clk) on_cnt_r <= rst ? 8'h00 : on_cnt_nxt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_off;
    $fell(pwm_on[0]);
  endsequence
  AST_SHORT: assert property (|short_cmp |=> fault && gate_a == 2'h0 && gate_b == 2'h0)
    else $error("short did not disable");
  AST_HEAT: assert property (thermal_trip |=> fault)
    else $error("thermal did not trip");
  AST_STICK: assert property (fault |=> fault)
    else $error("fault cleared");
  AST_LOW: assert property (fault |-> gate_a == 2'h0 && gate_b == 2'h0)
    else $error("gate high in fault");
  AST_DEAD: assert property (s_off |-> (gate_a == 2'h0)[*8])
    else $error("no dead time");
  AST_RECT: assert property (s_off ##14 !fault |-> gate_a != 2'h0)
    else $error("no rectification");
  AST_BLANK: assert property ($rose(pwm_on[0]) |-> (pwm_on[0] || fault)[*8])
    else $error("on period cut short");
  AST_TRIP: assert property (trip_cmp[0] && on_cnt_r >= 8'h50 |=> !pwm_on[0])
    else $error("trip ignored");
  AST_OPEN: assert property (open_event[0] |-> !$past(pwm_on[0]))
    else $error("open event in on period");
endmodule : pof_drive_ctrl_props

bind pof_drive_ctrl pof_drive_ctrl_props u_props (.clk(clk), .rst(rst), .trip_cmp(trip_cmp),
  .short_cmp(short_cmp), .thermal_trip(thermal_trip), .gate_a(gate_a), .gate_b(gate_b),
  .pwm_on(pwm_on), .open_event(open_event), .fault(fault));

// ==== bench/pof_drive_ctrl_tb.sv ====
// Purpose: Self-checking bench for pof_drive_ctrl
// Assumes: Coil models on both phases
// Notes:   Xorshift stimulus from a fixed seed
`timescale 1ns/1ps
module pof_drive_ctrl_tb;
  import pof_pkg::*;
  logic        clk;
  logic        rst;
  logic [1:0]  phase_en;
  logic [1:0]  phase_dir;
  pof_ratio_t  ref_ratio_a;
  pof_ratio_t  ref_ratio_b;
  logic [1:0]  trip_cmp;
  logic [1:0]  short_cmp;
  logic [1:0]  sense_pos;
  logic        thermal_trip;
  logic [1:0]  gate_a;
  logic [1:0]  gate_b;
  logic [1:0]  pwm_on;
  logic [1:0]  open_event;
  logic        fault;
  logic [1:0]  mode_a;
  logic [7:0]  on_len;
  logic [31:0] seed;
  int          failures;
  int          n_tests;
  int          ev_cnt;
  int          ton;
  int          toff;
  pof_drive_ctrl dut (.clk, .rst, .phase_en, .phase_dir, .ref_ratio_a, .ref_ratio_b, .trip_cmp,
    .short_cmp, .sense_pos, .thermal_trip, .gate_a, .gate_b, .pwm_on, .open_event, .fault);
  pof_coil_model u_ca (.clk, .gate(gate_a), .dir(phase_dir[0]), .mode(mode_a), .on_len,
    .trip(trip_cmp[0]), .pos(sense_pos[0]));
  pof_coil_model u_cb (.clk, .gate(gate_b), .dir(phase_dir[1]), .mode(2'h0), .on_len,
    .trip(trip_cmp[1]), .pos(sense_pos[1]));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    if (open_event[0] === 1'b1) ev_cnt++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [8:0] exp_off(input pof_ratio_t r);
    return (r >= 7'h46) ? 9'h12c : (r >= 7'h28) ? 9'h0ed : 9'h0af;
  endfunction : exp_off
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic do_reset();
    rst = 1'b1;
    seed = xs(seed);
    phase_dir = seed[1:0];
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("reset_out", 9'h000, {fault, 2'h0, gate_a, gate_b, pwm_on});
  endtask : do_reset
  // One on period, counted from the current cycle if already on, then the following off period
  task automatic measure();
    ton = 0;
    toff = 0;
    while (pwm_on[0] !== 1'b1 && toff < 1000) begin
      @(negedge clk);
      toff++;
    end
    toff = 0;
    while (pwm_on[0] === 1'b1 && ton < 1000) begin
      @(negedge clk);
      ton++;
    end
    while (pwm_on[0] !== 1'b1 && toff < 1000) begin
      @(negedge clk);
      toff++;
      if (toff == 5) chk("dead", 9'h000, {7'h00, gate_a});
      if (toff == 20) chk("rect", {7'h00, phase_dir[0] ? 2'h1 : 2'h2}, {7'h00, gate_a});
    end
  endtask : measure
  initial begin
    {phase_en, ref_ratio_a, ref_ratio_b, short_cmp, thermal_trip} = {2'h3, 7'h00, 7'h00, 3'h0};
    {rst, phase_dir, mode_a, on_len, seed} = {5'h10, 8'h64, 32'hf07e};
    {failures, n_tests, ev_cnt} = {32'h0, 32'h0, 32'h0};
    do_reset();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      while (pwm_on[0] === 1'b1) @(negedge clk);
      ref_ratio_a = (i < 4) ? (i[1] ? 7'h45 : 7'h27) + 7'(i[0]) : 7'(seed[7:0] % 8'h65);
      ref_ratio_b = {1'b0, seed[13:8]};
      phase_dir = seed[25:24];
      on_len = 8'h10 + {1'b0, seed[22:16]};
      measure();
      chk("off_len", exp_off(ref_ratio_a), 9'(toff));
      chk("blank", 9'h001, {8'h00, ton >= 80});
      chk("ton", (on_len > 8'h4f) ? {1'b0, on_len} + 9'h002 : 9'h051, 9'(ton));
    end
    ev_cnt = 0;
    for (int k = 0; k < 10; k++) begin
      mode_a = 2'(20'h545aa >> (2 * k));
      measure();
      repeat (3) @(negedge clk);
      chk("open_fault", {8'h00, k == 9}, {8'h00, fault});
    end
    chk("open_evt", 9'h005, 9'(ev_cnt));
    mode_a = 2'h0;
    repeat (400) @(negedge clk);
    chk("hold", 9'h100, {fault, 2'h0, gate_a, gate_b, pwm_on});
    for (int c = 0; c < 3; c++) begin
      do_reset();
      seed = xs(seed);
      repeat (seed[8:0] + 9'h001) @(negedge clk);
      short_cmp = (c < 2) ? 2'(1 << c) : 2'h0;
      thermal_trip = (c == 2);
      @(negedge clk);
      {short_cmp, thermal_trip} = 3'h0;
      chk("trip", 9'h100, {fault, 2'h0, gate_a, gate_b, pwm_on});
      repeat (100) @(negedge clk);
      chk("sticky", 9'h100, {fault, 2'h0, gate_a, gate_b, pwm_on});
    end
    do_reset();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule : pof_drive_ctrl_tb

// ==== hw/pof_drive_ctrl.sv ====
// Purpose: Fixed off-time PWM with synchronous rectification and latched protection
// Assumes: rst is the logic-supply power-on reset; comparators synchronous to clk
// Notes:   Two phases, each with two gate drives; index 0 is phase A
`timescale 1ns/1ps
module pof_drive_ctrl
  import pof_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] phase_en,
  input  wire logic [1:0] phase_dir,
  input  wire pof_ratio_t ref_ratio_a,
  input  wire pof_ratio_t ref_ratio_b,
  input  wire logic [1:0] trip_cmp,
  input  wire logic [1:0] short_cmp,
  input  wire logic [1:0] sense_pos,
  input  wire logic       thermal_trip,
  output logic [1:0]      gate_a,
  output logic [1:0]      gate_b,
  output logic [1:0]      pwm_on,
  output logic [1:0]      open_event,
  output logic            fault
);

  // ****************************************************************
  // Fault latch
  // ****************************************************************
  logic [1:0] open_trip;
  logic       fault_r;
  wire        fault_nxt;

  assign fault_nxt = fault_r | (|short_cmp) | thermal_trip | (|open_trip);

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault = fault_r;

  // ****************************************************************
  // Per-phase PWM sequencer
  // ****************************************************************
  pof_ratio_t ratio_w [2];
  logic [1:0] gate_w  [2];

  assign ratio_w[0] = ref_ratio_a;
  assign ratio_w[1] = ref_ratio_b;
  assign gate_a     = gate_w[0];
  assign gate_b     = gate_w[1];

  for (genvar p = 0; p < 2; p++) begin : g_ph
    pof_state_t st_r;
    pof_state_t st_nxt;
    pof_cnt_t   cnt_r;
    pof_cnt_t   off_len_r;
    logic       dir_r;
    logic [1:0] gate_r;
    logic       pwm_on_r;
    wire        blank_done;
    wire        on_end;
    wire        dead_done;
    wire        rect_done;
    wire        off_start;
    wire        off_end;
    wire        in_off;
    wire        change;
    wire [1:0]  gate_nxt;
    wire        dir_use;

    assign blank_done = (cnt_r >= BLANK_CYC);
    assign on_end     = trip_cmp[p] & blank_done;
    assign dead_done  = (cnt_r == DEAD_CYC - pof_cnt_t'(1));
    // off period from own clock count
    assign rect_done  = (cnt_r >= off_len_r - (DEAD_CYC << 1) - pof_cnt_t'(1));
    assign off_start  = (st_r == POF_ON) & (st_nxt == POF_DEAD_OFF);
    assign off_end    = (st_r == POF_DEAD_ON) & (st_nxt != POF_DEAD_ON);
    assign in_off     = (st_r == POF_DEAD_OFF) | (st_r == POF_RECT) |
                        (st_r == POF_DEAD_ON);
    assign change     = (st_nxt != st_r);

    always_comb begin
      st_nxt = st_r;
      case (st_r)
        POF_IDLE: begin
          if (phase_en[p]) begin
            st_nxt = POF_ON;
          end
        end
        POF_ON: begin
          if (!phase_en[p]) begin
            st_nxt = POF_IDLE;
          end else if (on_end) begin
            st_nxt = POF_DEAD_OFF;
          end
        end
        POF_DEAD_OFF: begin
          if (dead_done) begin
            st_nxt = POF_RECT;
          end
        end
        POF_RECT: begin
          if (rect_done) begin
            st_nxt = POF_DEAD_ON;
          end
        end
        POF_DEAD_ON: begin
          if (dead_done) begin
            st_nxt = phase_en[p] ? POF_ON : POF_IDLE;
          end
        end
        default: begin
          st_nxt = POF_IDLE;
        end
      endcase
      if (fault_nxt) begin
        st_nxt = POF_IDLE;
      end
    end

    // new direction only while both gates are off
    assign dir_use  = ((st_r == POF_IDLE) | off_end) ? phase_dir[p] : dir_r;
    // gates low same cycle as latch
    assign gate_nxt = fault_nxt ? 2'h0 : pof_gate(st_nxt, dir_use);

    always_ff @(posedge clk) begin
      if (rst) begin
        st_r  <= POF_IDLE;
        cnt_r <= '0;
      end else begin
        st_r  <= st_nxt;
        cnt_r <= change ? '0 : pof_sat_inc(cnt_r);
      end
    end

    // Direction held through the whole chopping cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        dir_r <= 1'b0;
      end else begin
        dir_r <= dir_use;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        off_len_r <= OFF_SHORT_CYC;
      end else if (st_r == POF_ON) begin
        off_len_r <= pof_off_len(ratio_w[p]);
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        gate_r   <= 2'h0;
        pwm_on_r <= 1'b0;
      end else begin
        gate_r   <= gate_nxt;
        pwm_on_r <= ~fault_nxt & (st_nxt == POF_ON);
      end
    end

    assign gate_w[p] = gate_r;
    assign pwm_on[p] = pwm_on_r;

    pof_open_det u_open (
      .clk        (clk),
      .rst        (rst),
      .off_start  (off_start),
      .in_off     (in_off),
      .off_end    (off_end),
      .sense_pos  (sense_pos[p]),
      .open_event (open_event[p]),
      .open_trip  (open_trip[p])
    );
  end

endmodule : pof_drive_ctrl

// ==== hw/pof_open_det.sv ====
// Purpose: Coil-open detection for one phase
// Assumes: Off-period strobes come from the phase PWM sequencer
// Notes:   Streak of detected periods survives only back to back
`timescale 1ns/1ps
module pof_open_det
  import pof_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic off_start,
  input  wire logic in_off,
  input  wire logic off_end,
  input  wire logic sense_pos,
  output logic      open_event,
  output logic      open_trip
);

  pof_cnt_t   ign_cnt_r;
  logic       det_r;
  logic [1:0] streak_r;
  logic [1:0] streak_nxt;
  wire        window_done;
  wire        det_now;
  wire        hit;

  assign window_done = (ign_cnt_r >= OPEN_IGN_CYC);
  assign det_now     = in_off & ~off_start & sense_pos & window_done;
  assign hit         = det_r | det_now;
  // consecutive count, reset by clean period
  assign streak_nxt  = hit ? streak_r + 2'h1 : 2'h0;

  always_ff @(posedge clk) begin
    if (rst || off_start) begin
      ign_cnt_r <= '0;
    end else if (in_off && !window_done) begin
      ign_cnt_r <= ign_cnt_r + pof_cnt_t'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || off_start) begin
      det_r <= 1'b0;
    end else if (det_now) begin
      det_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      streak_r <= 2'h0;
    end else if (off_end) begin
      streak_r <= streak_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      open_event <= 1'b0;
      open_trip  <= 1'b0;
    end else begin
      open_event <= det_now & ~det_r;
      open_trip  <= off_end & (streak_nxt == OPEN_TRIPS);
    end
  end

endmodule : pof_open_det

// ==== shared/pof_pkg.sv ====
// Purpose: Constants, types and helpers for the PWM off-time and fault protection block
// Assumes: 25 MHz clock; comparator inputs already synchronous to it
// Notes:   Times are kept in ns and turned into cycle counts here
//
// Functional notes
// - Off period counted on internal clock
// - Three off-time levels picked by ratio
// - Opposite switch conducts during off period
// - Both gates off for dead interval
// - Sense above short level disables outputs
// - Positive sense during off flags open
// - Three consecutive open periods trip protection
// - Ignore positive sense just after turn-off
// - Over-temperature disables every output
// - Trip holds until power-on reset
// - Sense reaching reference ends on period
// - Blank comparator right after turn-on
// - Off-time between 7 and 12 us
package pof_pkg;

  // ****************************************************************
  // Clock and cycle conversion
  // ****************************************************************
  localparam int CLK_NS = 40;

  function automatic int pof_cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : pof_cyc_up

  function automatic int pof_cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : pof_cyc_dn

  // ****************************************************************
  // Types
  // ****************************************************************
  localparam int CNT_W   = 9;
  localparam int RATIO_W = 7;

  typedef logic [CNT_W-1:0]   pof_cnt_t;
  typedef logic [RATIO_W-1:0] pof_ratio_t;

  typedef enum logic [2:0] {
    POF_IDLE,
    POF_ON,
    POF_DEAD_OFF,
    POF_RECT,
    POF_DEAD_ON
  } pof_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int DEAD_NS      = 500;
  localparam int BLANK_NS     = 3200;
  localparam int OFF_SHORT_NS = 7000;
  localparam int OFF_MID_NS   = 9500;
  localparam int OFF_LONG_NS  = 12000;
  localparam int OPEN_IGN_NS  = 2000;

  localparam pof_cnt_t DEAD_CYC      = pof_cnt_t'(pof_cyc_up(DEAD_NS));
  localparam pof_cnt_t BLANK_CYC     = pof_cnt_t'(pof_cyc_up(BLANK_NS));
  localparam pof_cnt_t OFF_SHORT_CYC = pof_cnt_t'(pof_cyc_dn(OFF_SHORT_NS));
  localparam pof_cnt_t OFF_MID_CYC   = pof_cnt_t'(pof_cyc_dn(OFF_MID_NS));
  localparam pof_cnt_t OFF_LONG_CYC  = pof_cnt_t'(pof_cyc_dn(OFF_LONG_NS));
  localparam pof_cnt_t OPEN_IGN_CYC  = pof_cnt_t'(pof_cyc_up(OPEN_IGN_NS));
  localparam pof_cnt_t CNT_MAX       = '1;

  // Ratio thresholds in percent of full reference
  localparam pof_ratio_t RATIO_MID = 7'h28;
  localparam pof_ratio_t RATIO_HI  = 7'h46;

  localparam logic [1:0] OPEN_TRIPS = 2'h3;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // level from ratio
  function automatic pof_cnt_t pof_off_len(input pof_ratio_t r);
    if (r >= RATIO_HI) begin
      return OFF_LONG_CYC;
    end else if (r >= RATIO_MID) begin
      return OFF_MID_CYC;
    end
    return OFF_SHORT_CYC;
  endfunction : pof_off_len

  function automatic pof_cnt_t pof_sat_inc(input pof_cnt_t c);
    return (c == CNT_MAX) ? c : c + pof_cnt_t'(1);
  endfunction : pof_sat_inc

  function automatic logic [1:0] pof_gate(input pof_state_t s, input logic dir);
    case (s)
      POF_ON:   return dir ? 2'h2 : 2'h1;
      POF_RECT: return dir ? 2'h1 : 2'h2;
      default:  return 2'h0;
    endcase
  endfunction : pof_gate

endpackage : pof_pkg
